// ==== design/grsc_consts.svh ====
// Purpose: Named constants for the guarded reset source controller
// Assumes: Included by the package and by every design file that needs numbers
// Notes:   Offsets are APB byte addresses, one 32-bit word per register
`ifndef GRSC_CONSTS_SVH
`define GRSC_CONSTS_SVH

// Clock and time figures
`define GRSC_CLK_PERIOD_NS   10
`define GRSC_SRESET_NS       1000
`define GRSC_LVR_NS          2000

// Register byte offsets
`define GRSC_ADDR_PIN        8'h00
`define GRSC_ADDR_FLAGS      8'h04
`define GRSC_ADDR_THR        8'h08
`define GRSC_ADDR_WDT        8'h0c
`define GRSC_ADDR_IRQ_STAT   8'h10
`define GRSC_ADDR_IRQ_CLR    8'h14
`define GRSC_ADDR_IRQ_EN     8'h18
`define GRSC_ADDR_STATUS     8'h1c

// Pin-function control codes and reset value
`define GRSC_PIN_POR         8'h55
`define GRSC_PIN_IO_SEL      8'h55
`define GRSC_PIN_RES_SEL     8'haa

// Threshold select codes and reset value
`define GRSC_THR_POR         8'h66
`define GRSC_THR_1V7         8'h66
`define GRSC_THR_1V9         8'h55
`define GRSC_THR_2V55        8'h33
`define GRSC_THR_3V15        8'h99
`define GRSC_THR_3V8         8'haa
`define GRSC_THR_OFF         8'hf0

// Watchdog control layout, codes and reset value
`define GRSC_WDT_POR         8'h52
`define GRSC_WDT_EN_MSB      7
`define GRSC_WDT_EN_LSB      3
`define GRSC_WDT_DISABLE     5'h15
`define GRSC_WDT_ENABLE      5'h0a

// Reset cause flag bits
`define GRSC_FLAG_W          4
`define GRSC_FLAG_PIN        3
`define GRSC_FLAG_LV         2
`define GRSC_FLAG_THR        1
`define GRSC_FLAG_WDT        0

// Interrupt status bits
`define GRSC_IRQ_W           6
`define GRSC_IRQ_PIN         0
`define GRSC_IRQ_THR         1
`define GRSC_IRQ_LV          2
`define GRSC_IRQ_WDT         3
`define GRSC_IRQ_EXT         4
`define GRSC_IRQ_TO          5

// Status register bits
`define GRSC_STAT_TO         0
`define GRSC_STAT_LP         1
`define GRSC_STAT_LVRUN      2

`endif

// ==== design/grsc_pkg.sv ====
// Purpose: Types and decode helpers for the guarded reset source controller
// Assumes: Constants come from the shared header
// Notes:   Threshold decode is shared by the register logic and the supervisor gate
`include "grsc_consts.svh"

package grsc_pkg;

    // Supervisor level selected by the threshold code
    typedef enum logic [2:0] {
        GRSC_LV_1V7,
        GRSC_LV_1V9,
        GRSC_LV_2V55,
        GRSC_LV_3V15,
        GRSC_LV_3V8,
        GRSC_LV_OFF,
        GRSC_LV_BAD
    } grsc_lv_level_t;

    // Map a threshold code to a level; anything undefined is flagged bad
    function automatic grsc_lv_level_t grsc_lv_decode(input logic [7:0] code);
        case (code)
            `GRSC_THR_1V7:  return GRSC_LV_1V7;
            `GRSC_THR_1V9:  return GRSC_LV_1V9;
            `GRSC_THR_2V55: return GRSC_LV_2V55;
            `GRSC_THR_3V15: return GRSC_LV_3V15;
            `GRSC_THR_3V8:  return GRSC_LV_3V8;
            `GRSC_THR_OFF:  return GRSC_LV_OFF;
            default:        return GRSC_LV_BAD;
        endcase
    endfunction

endpackage

// ==== design/grsc_cnt_if.sv ====
// Purpose: Run/fire pairing between the controller and a qualify counter
// Assumes: Both ends share pclk
// Notes:   fire is a one-cycle pulse from a flip-flop
interface grsc_cnt_if;
    logic run;   // Condition being qualified, level
    logic fire;  // Qualified, one-cycle pulse

    modport ctrl (output run, input fire);
    modport cnt  (input run, output fire);
endinterface

// ==== design/grsc_qual_cnt.sv ====
// Purpose: Fires once after its run input has held for COUNT clock cycles
// Assumes: run is synchronous to pclk
// Notes:   Re-arms only when run drops, so a stuck condition fires once
module grsc_qual_cnt #(
    parameter int COUNT = 100
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    grsc_cnt_if.cnt    port
);
    localparam int W = $clog2(COUNT) + 1;

    logic [W-1:0] cnt_q;   // Cycles run has held so far
    logic         done_q;  // Already fired for this episode
    logic         fire_q;  // Pulse register

    // Count consecutive run cycles; any gap restarts from zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
            fire_q <= 1'b0;
        end else if (!port.run) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
            fire_q <= 1'b0;
        end else if (!done_q && cnt_q == W'(COUNT - 1)) begin
            fire_q <= 1'b1;
            done_q <= 1'b1;
        end else begin
            cnt_q  <= done_q ? cnt_q : cnt_q + W'(1);
            fire_q <= 1'b0;
        end
    end

    assign port.fire = fire_q;
endmodule

// ==== design/grsc_irq_ctrl.sv ====
// Purpose: Sticky event status, enable mask and one level interrupt
// Assumes: Clear strobe comes from a write to the clear register
// Notes:   An event in the same cycle as its clear stays set
module grsc_irq_ctrl #(
    parameter int W = 6
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] set_vec,
    input  wire logic         clr_we,
    input  wire logic         en_we,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] status_q,
    output logic      [W-1:0] enable_q,
    output logic              irq_q
);
    // Sticky status; set beats write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~(clr_we ? wdata : '0)) | set_vec;
        end
    end

    // Enable mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= '0;
        end else if (en_we) begin
            enable_q <= wdata;
        end
    end

    // Level output, one cycle behind status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & enable_q);
        end
    end
endmodule

// ==== design/grsc_top.sv ====
// Purpose: Reset source controller with noise-guarded control registers
// Assumes: All inputs synchronous to pclk; presetn is the power-on reset
// Notes:   Reset requests leave as a one-cycle pulse on sys_reset_q
//
// Decided for this implementation: the APB register port and the register offsets.
`include "grsc_consts.svh"

module grsc_top
    import grsc_pkg::*;
#(
    parameter int SRESET_CYCLES = (`GRSC_SRESET_NS + `GRSC_CLK_PERIOD_NS - 1) / `GRSC_CLK_PERIOD_NS,
    parameter int LVR_CYCLES    = `GRSC_LVR_NS / `GRSC_CLK_PERIOD_NS + 1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata_q,
    output logic             pready_q,
    output logic             pslverr_q,
    input  wire logic        external_reset_pin_n,
    input  wire logic        low_supply,
    input  wire logic        low_power_mode,
    input  wire logic        wdt_timeout,
    output logic             sys_reset_q,
    output logic             pin_is_reset_q,
    output grsc_lv_level_t   lv_level_q,
    output logic             lv_monitor_on_q,
    output logic             wdt_enable_q,
    output logic             irq_q
);

    // Software-visible registers
    logic [7:0]               pin_ctrl_q;   // Shared pin function select
    logic [7:0]               thr_q;        // Supervisor threshold code
    logic [7:0]               wdt_q;        // Watchdog control word
    logic [`GRSC_FLAG_W-1:0]  flags_q;      // Sticky reset cause flags
    logic                     to_flag_q;    // Watchdog timeout status
    logic [`GRSC_IRQ_W-1:0]   irq_stat;     // Sticky event status
    logic [`GRSC_IRQ_W-1:0]   irq_en;       // Event enable mask

    // Decoded conditions
    grsc_lv_level_t           lv_level;     // Current threshold decode
    logic                     pin_bad;      // Pin control holds an undefined code
    logic                     thr_bad;      // Threshold holds an undefined code
    logic                     wdt_bad;      // Watchdog field holds an undefined code
    logic                     pin_rst;      // Pin driven low in reset mode
    logic                     wdt_act_rst;  // Timeout while running
    logic                     guard_fire;   // Guarded delay expired
    logic                     lv_fire;      // Low supply qualified
    logic                     lv_run;       // Supervisor sees a live low supply
    logic                     hw_rst;       // Any reset this cycle
    logic                     rst_not_lv;   // Any reset other than low voltage

    // Bus strobes
    logic                     setup_ph;     // APB setup cycle
    logic                     wr_acc;       // Completing write
    logic                     addr_ok;      // Address is mapped

    grsc_cnt_if guard_if ();
    grsc_cnt_if lv_if ();

    // Only these two codes are legal for the pin control
    assign pin_bad = (pin_ctrl_q != `GRSC_PIN_IO_SEL) &&
                     (pin_ctrl_q != `GRSC_PIN_RES_SEL);
    assign lv_level = grsc_lv_decode(thr_q);
    assign thr_bad  = (lv_level == GRSC_LV_BAD);
    assign wdt_bad  = (wdt_q[`GRSC_WDT_EN_MSB:`GRSC_WDT_EN_LSB] != `GRSC_WDT_DISABLE) &&
                      (wdt_q[`GRSC_WDT_EN_MSB:`GRSC_WDT_EN_LSB] != `GRSC_WDT_ENABLE);

    // Pin acts as a reset input only when the reset code is selected
    assign pin_rst = (pin_ctrl_q == `GRSC_PIN_RES_SEL) && !external_reset_pin_n;

    // A sleeping timeout is only a warm restart and does not count here
    assign wdt_act_rst = wdt_timeout && !low_power_mode;

    // Supervisor is gated off in low power and when disabled or corrupt
    // Corrupt codes are left to the guard counter, not the supervisor
    assign lv_run = low_supply && !low_power_mode &&
                    (lv_level != GRSC_LV_OFF) && !thr_bad;

    // Low-voltage reset stays apart because it must spare the threshold
    assign rst_not_lv = guard_fire || pin_rst || wdt_act_rst;
    assign hw_rst     = rst_not_lv || lv_fire;

    // Guarded delay: any corrupt control word must stay corrupt the full count
    assign guard_if.run = pin_bad || thr_bad || wdt_bad;
    assign guard_fire   = guard_if.fire;

    // One counter serves all three registers: a second corruption during a
    // count does not restart it, so the reset follows the first one's delay
    grsc_qual_cnt #(
        .COUNT (SRESET_CYCLES)
    ) u_guard (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (guard_if)
    );

    // Low supply qualification: shorter dips never reach fire
    assign lv_if.run = lv_run;
    assign lv_fire   = lv_if.fire;

    // Fires once per episode; the supply must recover before it fires again
    grsc_qual_cnt #(
        .COUNT (LVR_CYCLES)
    ) u_lv (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (lv_if)
    );

    // APB decode; pready is high from the first edge after reset so every access phase completes
    // Writes to the event status word or to unmapped offsets are dropped
    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite && pready_q;
    assign addr_ok  = (paddr == `GRSC_ADDR_PIN)      || (paddr == `GRSC_ADDR_FLAGS)   ||
                      (paddr == `GRSC_ADDR_THR)      || (paddr == `GRSC_ADDR_WDT)     ||
                      (paddr == `GRSC_ADDR_IRQ_STAT) || (paddr == `GRSC_ADDR_IRQ_CLR) ||
                      (paddr == `GRSC_ADDR_IRQ_EN)   || (paddr == `GRSC_ADDR_STATUS);

    // Pin control: power-on value, restored by every reset seen here
    // A write landing with a reset is lost, the reset takes priority
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ctrl_q <= `GRSC_PIN_POR;
        end else if (hw_rst) begin
            pin_ctrl_q <= `GRSC_PIN_POR;
        end else if (wr_acc && paddr == `GRSC_ADDR_PIN) begin
            pin_ctrl_q <= pwdata[7:0];
        end
    end

    // Threshold: a true low-voltage reset leaves it alone
    // The low-voltage branch keeps the code as it is and drops a write landing in that cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_q <= `GRSC_THR_POR;
        end else if (rst_not_lv) begin
            thr_q <= `GRSC_THR_POR;
        end else if (lv_fire) begin
            thr_q <= thr_q;
        end else if (wr_acc && paddr == `GRSC_ADDR_THR) begin
            thr_q <= pwdata[7:0];
        end
    end

    // Watchdog control: restored by any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_q <= `GRSC_WDT_POR;
        end else if (hw_rst) begin
            wdt_q <= `GRSC_WDT_POR;
        end else if (wr_acc && paddr == `GRSC_ADDR_WDT) begin
            wdt_q <= pwdata[7:0];
        end
    end

    // Cause flags: writing one keeps a bit, zero clears it, set wins
    // Low-voltage flag starts clear so software never reads an unknown
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
        end else begin
            flags_q <= ((wr_acc && paddr == `GRSC_ADDR_FLAGS) ?
                        (flags_q & pwdata[`GRSC_FLAG_W-1:0]) : flags_q)
                     | {guard_fire && pin_bad,
                        lv_fire,
                        guard_fire && thr_bad,
                        guard_fire && wdt_bad};
        end
    end

    // Timeout flag: set by any timeout, cleared by writing zero
    // A sleeping timeout still sets it, though it issues no reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_flag_q <= 1'b0;
        end else if (wdt_timeout) begin
            to_flag_q <= 1'b1;
        end else if (wr_acc && paddr == `GRSC_ADDR_STATUS && !pwdata[`GRSC_STAT_TO]) begin
            to_flag_q <= 1'b0;
        end
    end

    // Outgoing reset pulse and decoded controls
    // Each output lags its cause by one edge, as all come from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset_q     <= 1'b0;
            pin_is_reset_q  <= 1'b0;
            lv_level_q      <= GRSC_LV_1V7;
            lv_monitor_on_q <= 1'b0;
            wdt_enable_q    <= 1'b0;
        end else begin
            sys_reset_q     <= hw_rst;
            pin_is_reset_q  <= (pin_ctrl_q == `GRSC_PIN_RES_SEL);
            lv_level_q      <= lv_level;
            lv_monitor_on_q <= !low_power_mode && !thr_bad &&
                               (lv_level != GRSC_LV_OFF);
            wdt_enable_q    <= (wdt_q[`GRSC_WDT_EN_MSB:`GRSC_WDT_EN_LSB] ==
                                `GRSC_WDT_ENABLE);
        end
    end

    // Event status, mask and interrupt
    // Pin reset and timeout re-set their status bits while they stand,
    // so a clear in the same cycle as the event does not take
    grsc_irq_ctrl #(
        .W (`GRSC_IRQ_W)
    ) u_irq (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_vec  ({wdt_timeout, pin_rst, guard_fire && wdt_bad, lv_fire,
                    guard_fire && thr_bad, guard_fire && pin_bad}),
        .clr_we   (wr_acc && paddr == `GRSC_ADDR_IRQ_CLR),
        .en_we    (wr_acc && paddr == `GRSC_ADDR_IRQ_EN),
        .wdata    (pwdata[`GRSC_IRQ_W-1:0]),
        .status_q (irq_stat),
        .enable_q (irq_en),
        .irq_q    (irq_q)
    );

    // Read data is prepared in the setup cycle, so the access phase needs no wait
    // pslverr_q stands until the next setup and means something only in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
            pready_q  <= 1'b0;
        end else begin
            pready_q <= 1'b1;
            if (setup_ph) begin
                pslverr_q <= !addr_ok;
                case (paddr)
                    `GRSC_ADDR_PIN:      prdata_q <= {24'h0, pin_ctrl_q};
                    `GRSC_ADDR_FLAGS:    prdata_q <= {28'h0, flags_q};
                    `GRSC_ADDR_THR:      prdata_q <= {24'h0, thr_q};
                    `GRSC_ADDR_WDT:      prdata_q <= {24'h0, wdt_q};
                    `GRSC_ADDR_IRQ_STAT: prdata_q <= {26'h0, irq_stat};
                    `GRSC_ADDR_IRQ_EN:   prdata_q <= {26'h0, irq_en};
                    `GRSC_ADDR_STATUS:   prdata_q <= {29'h0, lv_run, low_power_mode, to_flag_q};
                    // Clear register and unmapped addresses read zero
                    default:             prdata_q <= '0;
                endcase
            end
        end
    end

    // Checks on the reset sources
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Power-on contents, seen at the first edge after release
    por_value_a: assert property ($rose(presetn) |->
        pin_ctrl_q == `GRSC_PIN_POR && thr_q == `GRSC_THR_POR && flags_q == '0)
        else $error("control registers not at power-on values");

    // Pin mode output lags the register by one edge
    pin_mode_a: assert property (
        pin_is_reset_q == ($past(pin_ctrl_q) == `GRSC_PIN_RES_SEL))
        else $error("pin mode output does not follow pin control");

    // Guarded resets restore and flag in the cycle after the fire
    pin_flag_a: assert property (guard_fire && pin_bad |=> flags_q[`GRSC_FLAG_PIN]
        && pin_ctrl_q == `GRSC_PIN_POR && sys_reset_q)
        else $error("pin control guard reset missed flag or restore");

    thr_guard_a: assert property (guard_fire && thr_bad |=>
        thr_q == `GRSC_THR_POR && flags_q[`GRSC_FLAG_THR] && sys_reset_q)
        else $error("threshold guard reset missed restore or flag");

    wdt_guard_a: assert property (guard_fire && wdt_bad |=>
        wdt_q == `GRSC_WDT_POR && flags_q[`GRSC_FLAG_WDT] && sys_reset_q)
        else $error("watchdog guard reset missed restore or flag");

    // The pin control flag rises only on its own cause; upper bits read zero
    flag_src_a: assert property ($rose(flags_q[`GRSC_FLAG_PIN]) |->
        $past(guard_fire) && $past(pin_bad))
        else $error("pin control flag set without cause");

    flag_rd_a: assert property (setup_ph && paddr == `GRSC_ADDR_FLAGS |=>
        prdata_q[31:`GRSC_FLAG_W] == '0)
        else $error("flag register upper bits not zero");

    // Supervisor: persistence, kept threshold, low power gate
    lv_qual_a: assert property ($rose(lv_fire) |->
        $past(lv_run, 1) && $past(lv_run, 2))
        else $error("low voltage reset without persistent low supply");
    lv_keep_a: assert property (lv_fire && !rst_not_lv |=>
        flags_q[`GRSC_FLAG_LV] && $stable(thr_q) && sys_reset_q)
        else $error("low voltage reset altered threshold or missed flag");
    lp_gate_a: assert property (low_power_mode |-> !lv_run ##1 !lv_fire)
        else $error("supervisor active in low power mode");
    lp_mon_a: assert property (low_power_mode |=> !lv_monitor_on_q)
        else $error("supervisor shown on in low power mode");

    // Timeouts awake reset fully; asleep they only set the flag
    to_pin_a: assert property (wdt_act_rst |=> to_flag_q && sys_reset_q
        && wdt_q == `GRSC_WDT_POR)
        else $error("active timeout did not reset and flag");

    to_warm_a: assert property (wdt_timeout && !hw_rst |=>
        to_flag_q && !sys_reset_q)
        else $error("warm timeout issued a reset or missed its flag");

    // Pin reset drops the reset function one edge after its pulse
    ext_rst_a: assert property (pin_rst |=> sys_reset_q ##1 !pin_is_reset_q)
        else $error("pin reset not issued");

    // Watchdog enable output follows the field; vacuous at the edge of release
    wdt_en_a: assert property ($past(presetn) |->
        wdt_enable_q == ($past(wdt_q[`GRSC_WDT_EN_MSB:`GRSC_WDT_EN_LSB]) == `GRSC_WDT_ENABLE))
        else $error("watchdog enable output does not follow the field");

    guard_wait_a: assert property ($rose(guard_if.run) |-> !guard_fire[*2])
        else $error("guarded reset fired early");

    // Main scenarios
    guard_fire_c: cover property (guard_fire && thr_bad);
    lv_fire_c:    cover property (lv_fire);
    to_active_c:  cover property (wdt_act_rst);
    pin_rst_c:    cover property (pin_rst);
    to_warm_c:    cover property (wdt_timeout && low_power_mode);
endmodule

// ==== verif/grsc_far_side.sv ====
// Purpose: Model of the external reset circuit and the supply monitor
// Assumes: The bench calls its tasks; all changes land just after pclk rises
// Notes:   The pin idles high through its pull-up; supply reads good between dips
module grsc_far_side (
    input  wire logic pclk,
    output logic      rst_pin_n,
    output logic      low_supply
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pull-up holds the pin high, supply starts good
    initial begin
        rst_pin_n  = 1'b1;
        low_supply = 1'b0;
    end

    // Pull the pin low for n cycles, then let the pull-up take it back
    task automatic pull_pin(input int n);
        @(posedge pclk) rst_pin_n <= 1'b0;
        repeat (n) @(posedge pclk);
        rst_pin_n <= 1'b1;
    endtask

    // Low-supply episode lasting n cycles
    task automatic dip(input int n);
        @(posedge pclk) low_supply <= 1'b1;
        repeat (n) @(posedge pclk);
        low_supply <= 1'b0;
    endtask
endmodule

// ==== verif/grsc_top_tb.sv ====
// Purpose: Self-checking bench for the reset source controller
// Assumes: Short guard and qualify counts keep the run brief
// Notes:   Reset pulses are counted at every edge and compared as deltas
`include "grsc_consts.svh"

module grsc_top_tb
    import grsc_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SR = 6;  // Guard delay in cycles
    localparam int LV = 8;  // Qualify time in cycles
    logic           pclk, presetn, psel, penable, pwrite, lpm, wto;
    logic [7:0]     paddr;
    logic [31:0]    pwdata, prdata_q, r;
    logic           pready_q, pslverr_q, pin_n, low_supply, sys_reset_q;
    logic           pin_is_reset_q, lv_monitor_on_q, wdt_enable_q, irq_q;
    grsc_lv_level_t lv_level_q;
    int             n_mismatch, compares, n_rst, n0;

    grsc_top #(.SRESET_CYCLES(SR), .LVR_CYCLES(LV)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
        .pready_q, .pslverr_q, .external_reset_pin_n(pin_n), .low_supply,
        .low_power_mode(lpm), .wdt_timeout(wto), .sys_reset_q, .pin_is_reset_q,
        .lv_level_q, .lv_monitor_on_q, .wdt_enable_q, .irq_q);
    grsc_far_side u_far (.pclk, .rst_pin_n(pin_n), .low_supply);

    // Free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Count reset pulses; the pulse stands one cycle
    always @(posedge pclk) if (sys_reset_q === 1'b1) n_rst++;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One APB transfer; waits for pready rather than assuming latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_q !== 1'b1);
        r = prdata_q;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic t_por;
        rd(`GRSC_ADDR_PIN, 32'h55);
        rd(`GRSC_ADDR_THR, 32'h66);
        rd(`GRSC_ADDR_FLAGS, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, pslverr_q}, 32'h1);
        $display("t_por done");
    endtask

    // Corrupt pin control: abort, then a real guarded reset and its flag
    task automatic t_pin_guard;
        wr(`GRSC_ADDR_IRQ_EN, 32'h3f);
        n0 = n_rst;
        wr(`GRSC_ADDR_PIN, 32'h12);
        wr(`GRSC_ADDR_PIN, 32'h55);
        cyc(SR + 3);
        chk(n_rst - n0, 0);
        wr(`GRSC_ADDR_PIN, 32'h12);
        cyc(SR + 3);
        chk(n_rst - n0, 1);
        rd(`GRSC_ADDR_FLAGS, 32'h08);
        rd(`GRSC_ADDR_PIN, 32'h55);
        chk({31'h0, irq_q}, 32'h1);
        rd(`GRSC_ADDR_IRQ_STAT, 32'h01);
        wr(`GRSC_ADDR_IRQ_CLR, 32'h3f);
        cyc(2);
        chk({31'h0, irq_q}, 32'h0);
        wr(`GRSC_ADDR_FLAGS, 32'hff);
        rd(`GRSC_ADDR_FLAGS, 32'h08);
        wr(`GRSC_ADDR_FLAGS, 32'h00);
        rd(`GRSC_ADDR_FLAGS, 32'h00);
        $display("t_pin_guard done");
    endtask

    // Every threshold code, then an undefined one
    task automatic t_thr;
        logic [7:0] codes [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0};
        for (int i = 0; i < 6; i++) begin
            wr(`GRSC_ADDR_THR, {24'h0, codes[i]});
            cyc(2);
            chk({29'h0, lv_level_q}, i);
        end
        chk({31'h0, lv_monitor_on_q}, 32'h0);
        n0 = n_rst;
        wr(`GRSC_ADDR_THR, 32'h77);
        cyc(SR + 3);
        chk(n_rst - n0, 1);
        rd(`GRSC_ADDR_THR, 32'h66);
        rd(`GRSC_ADDR_FLAGS, 32'h02);
        wr(`GRSC_ADDR_FLAGS, 32'h00);
        $display("t_thr done");
    endtask

    // Short dip ignored, long dip resets, low power masks it
    task automatic t_lv;
        wr(`GRSC_ADDR_THR, 32'h55);
        n0 = n_rst;
        u_far.dip(LV - 2);
        cyc(3);
        chk(n_rst - n0, 0);
        u_far.dip(LV + 2);
        cyc(3);
        chk(n_rst - n0, 1);
        rd(`GRSC_ADDR_FLAGS, 32'h04);
        rd(`GRSC_ADDR_THR, 32'h55);
        wr(`GRSC_ADDR_FLAGS, 32'h00);
        @(posedge pclk) lpm <= 1'b1;
        u_far.dip(LV + 2);
        cyc(3);
        chk(n_rst - n0, 1);
        @(posedge pclk) lpm <= 1'b0;
        $display("t_lv done");
    endtask

    // Pin ignored in I/O mode, then a reset input pulled low from outside
    task automatic t_pin;
        n0 = n_rst;
        u_far.pull_pin(3);
        cyc(3);
        chk(n_rst - n0, 0);
        wr(`GRSC_ADDR_PIN, 32'haa);
        cyc(2);
        chk({31'h0, pin_is_reset_q}, 32'h1);
        n0 = n_rst;
        u_far.pull_pin(3);
        cyc(3);
        chk(n_rst - n0, 1);
        rd(`GRSC_ADDR_PIN, 32'h55);
        $display("t_pin done");
    endtask

    task automatic pulse_to;
        @(posedge pclk) wto <= 1'b1;
        @(posedge pclk) wto <= 1'b0;
        cyc(3);
    endtask

    // Watchdog field codes and timeouts awake and asleep
    task automatic t_wdt;
        wr(`GRSC_ADDR_WDT, 32'ha8);
        cyc(2);
        chk({31'h0, wdt_enable_q}, 32'h0);
        n0 = n_rst;
        wr(`GRSC_ADDR_WDT, 32'h00);
        cyc(SR + 3);
        chk(n_rst - n0, 1);
        rd(`GRSC_ADDR_FLAGS, 32'h01);
        rd(`GRSC_ADDR_WDT, 32'h52);
        chk({31'h0, wdt_enable_q}, 32'h1);
        pulse_to();
        chk(n_rst - n0, 2);
        rd(`GRSC_ADDR_STATUS, 32'h01);
        wr(`GRSC_ADDR_STATUS, 32'h00);
        wr(`GRSC_ADDR_PIN, 32'haa);
        @(posedge pclk) lpm <= 1'b1;
        pulse_to();
        chk(n_rst - n0, 2);
        rd(`GRSC_ADDR_STATUS, 32'h03);
        rd(`GRSC_ADDR_PIN, 32'haa);
        @(posedge pclk) lpm <= 1'b0;
        $display("t_wdt done");
    endtask

    task automatic print_verdict;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #100us;
        n_mismatch++;
        print_verdict();
    end

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, lpm, wto} = '0;
        paddr  = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_por();
        t_pin_guard();
        t_thr();
        t_lv();
        t_pin();
        t_wdt();
        print_verdict();
    end
endmodule
